// *** rtl/mcseq_pkg.sv ***
`default_nettype none
package mcseq_pkg;
   localparam int PC_W = 12;
   localparam int STACK_DEPTH = 6;
   localparam logic [7:0] ADDR_PTR_ONE = 8'h80;
   localparam logic [7:0] ADDR_PTR_TWO = 8'h81;
   localparam logic [7:0] ADDR_SHORT_ONE = 8'h82;
   localparam logic [7:0] ADDR_SHORT_TWO = 8'h83;
   localparam logic [7:0] BANK_LO = 8'h00;
   localparam logic [7:0] BANK_HI = 8'h3f;
   localparam logic [7:0] WIN_LO = 8'h40;
   localparam logic [7:0] WIN_HI = 8'h7f;
   localparam logic [7:0] RAM_LO = 8'h80;
   localparam logic [7:0] RAM_HI = 8'hbf;
   localparam logic [11:0] PRG_RSV_HI = 12'h07f;
   localparam logic [11:0] PRG_USER_HI = 12'hf9f;
   localparam logic [11:0] VEC_IRQ_LO = 12'hff0;
   localparam logic [11:0] VEC_IRQ_HI = 12'hff7;
   localparam logic [11:0] VEC_NMI = 12'hffc;
   localparam logic [11:0] VEC_RESET = 12'hffe;
   localparam logic [7:0] REG_RESET = 8'h00;
   typedef enum logic [1:0] {CTX_NORMAL, CTX_IRQ, CTX_NMI} mcseq_ctx_e;
   typedef enum logic [2:0] {
      PCOP_NEXT, PCOP_HOLD, PCOP_JUMP, PCOP_REL, PCOP_VECTOR, PCOP_RETURN
   } mcseq_pcop_e;
   typedef enum logic [2:0] {
      DSP_BANK, DSP_WINDOW, DSP_CORE_REG, DSP_RAM, DSP_OTHER
   } mcseq_dsp_e;
   typedef enum logic [1:0] {
      PSP_RESERVED, PSP_USER, PSP_VECTOR, PSP_OTHER
   } mcseq_psp_e;
endpackage
`default_nettype wire

// *** rtl/mcseq_stack_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface mcseq_stack_if;
   logic push;
   logic pop;
   logic [11:0] push_data;
   logic [11:0] top;
   logic empty;
   modport owner (output push, output pop, output push_data, input top, input empty);
   modport stack (input push, input pop, input push_data, output top, output empty);
endinterface
`default_nettype wire

// *** rtl/mcseq_stack.sv ***
`timescale 1ns/1ns
`default_nettype none
module mcseq_stack
   import mcseq_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   mcseq_stack_if.stack sif
);
   logic [11:0] level_reg [DEPTH];
   logic [3:0] depth_reg;

   // =========================================
   // shift register levels
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_lvl
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               level_reg[i] <= 12'h000;
            end else if (ce && sif.push) begin
               level_reg[i] <= (i == 0) ? sif.push_data : level_reg[(i == 0) ? 0 : i - 1];
            end else if (ce && sif.pop && depth_reg != 4'h0) begin
               level_reg[i] <= (i == DEPTH - 1) ? 12'h000 : level_reg[(i == DEPTH - 1) ? i : i + 1];
            end
         end
      end
   endgenerate

   // depth saturates both ways
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         depth_reg <= 4'h0;
      end else if (ce && sif.push) begin
         if (depth_reg != 4'(DEPTH)) begin
            depth_reg <= depth_reg + 4'h1;
         end
      end else if (ce && sif.pop && depth_reg != 4'h0) begin
         depth_reg <= depth_reg - 4'h1;
      end
   end

   assign sif.top = level_reg[0];
   assign sif.empty = (depth_reg == 4'h0);

   a_depth_sat: assert property (@(posedge mclk) disable iff (!nrst)
      depth_reg <= 4'(DEPTH)) else $error("stack depth past limit");
   a_pop_empty: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && sif.pop && !sif.push && sif.empty) |=> sif.empty) else $error("pop of empty moved");
   a_push_top: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && sif.push) |=> sif.top == $past(sif.push_data)) else $error("push lost data");
   a_pop_shift: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && sif.pop && !sif.push && !sif.empty) |=> sif.top == $past(level_reg[1]))
      else $error("pop did not shift");
endmodule // mcseq_stack
`default_nettype wire

// *** rtl/mcseq_flags.sv ***
`timescale 1ns/1ns
`default_nettype none
module mcseq_flags
   import mcseq_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [1:0] ctx,
   input wire logic carry_we,
   input wire logic carry_in,
   input wire logic zero_we,
   input wire logic [7:0] result,
   output logic carry,
   output logic zero
);
   logic [2:0] carry_reg;
   logic [2:0] zero_reg;

   // =========================================
   // one pair per context, never cleared on switch
   generate
      for (genvar i = 0; i < 3; i++) begin : g_pair
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               carry_reg[i] <= 1'b0;
               zero_reg[i] <= 1'b0;
            end else if (ce && ctx == 2'(i)) begin
               if (carry_we) begin
                  carry_reg[i] <= carry_in;
               end
               if (zero_we) begin
                  zero_reg[i] <= (result == 8'h00);
               end
            end
         end
      end
   endgenerate

   assign carry = carry_reg[ctx];
   assign zero = zero_reg[ctx];

   a_keep: assert property (@(posedge mclk) disable iff (!nrst)
      (ctx != 2'd0) |=> carry_reg[0] == $past(carry_reg[0])) else $error("idle pair changed");
   a_zero: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && zero_we && ctx != 2'd3) |=> zero == ($past(result) == 8'h00) || ctx != $past(ctx))
      else $error("zero flag wrong");
endmodule // mcseq_flags
`default_nettype wire

// *** rtl/mcu_core_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module mcu_core_sequencer
   import mcseq_pkg::*;
#(
   parameter int BANK_W = 1
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   // sequencing commands from decode
   input wire logic fetch,
   input wire logic [2:0] pc_op,
   input wire logic is_call,
   input wire logic [11:0] jump_target,
   input wire logic [7:0] rel_offset,
   input wire logic irq_take,
   input wire logic nmi_take,
   input wire logic [1:0] irq_vec_sel,
   input wire logic is_return_from_interrupt,
   input wire logic [BANK_W-1:0] prog_bank,
   input wire logic [6:0] window_sel,
   // flag updates
   input wire logic carry_we,
   input wire logic carry_in,
   input wire logic zero_we,
   input wire logic [7:0] alu_result,
   // data space access
   input wire logic [7:0] data_addr,
   input wire logic data_we,
   input wire logic [7:0] data_wdata,
   // program ROM
   input wire logic [7:0] rom_rdata,
   output logic [11:0] program_counter,
   output logic [BANK_W+11:0] rom_addr,
   output logic [12:0] window_rom_addr,
   output logic busy,
   output logic [1:0] active_ctx,
   output logic carry,
   output logic zero,
   output logic [7:0] core_rdata,
   output logic core_hit,
   output logic [2:0] data_region,
   output logic [1:0] prog_region,
   output logic [7:0] pointer_one,
   output logic [7:0] pointer_two
);
   typedef enum logic [1:0] {ST_RUN, ST_VEC_LO, ST_VEC_HI} mcseq_st_e;

   mcseq_st_e state_reg;
   logic [11:0] pc_reg;
   logic [11:0] vec_addr_reg;
   logic [7:0] vec_lo_reg;
   logic [1:0] ctx_reg;
   logic [1:0] prev_ctx_reg;
   logic [7:0] ptr_one_reg;
   logic [7:0] ptr_two_reg;
   logic [7:0] short_one_reg;
   logic [7:0] short_two_reg;
   logic [11:0] pc_next;
   logic [11:0] rel_sum;
   logic taking_int;
   logic ret_go;

   mcseq_stack_if sif();

   // =========================================
   // map decoders
   function automatic logic [2:0] data_map(input logic [7:0] a);
      if (a <= BANK_HI) begin
         data_map = DSP_BANK;
      end else if (a >= WIN_LO && a <= WIN_HI) begin
         data_map = DSP_WINDOW;
      end else if (a >= ADDR_PTR_ONE && a <= ADDR_SHORT_TWO) begin
         data_map = DSP_CORE_REG;
      end else if (a <= RAM_HI) begin
         data_map = DSP_RAM;
      end else begin
         data_map = DSP_OTHER;
      end
   endfunction

   function automatic logic [1:0] prog_map(input logic [11:0] a);
      if (a <= PRG_RSV_HI) begin
         prog_map = PSP_RESERVED;
      end else if (a <= PRG_USER_HI) begin
         prog_map = PSP_USER;
      end else if ((a >= VEC_IRQ_LO && a <= VEC_IRQ_HI) || a >= VEC_NMI) begin
         prog_map = PSP_VECTOR;
      end else begin
         prog_map = PSP_OTHER;
      end
   endfunction

   assign data_region = data_map(data_addr);
   assign prog_region = prog_map(pc_reg);

   // =========================================
   // program counter
   assign rel_sum = pc_reg + {{4{rel_offset[7]}}, rel_offset};
   assign taking_int = irq_take || nmi_take;
   assign ret_go = (pc_op == PCOP_RETURN) && !sif.empty;

   always_comb begin
      pc_next = pc_reg;
      case (pc_op)
         PCOP_NEXT: pc_next = pc_reg + 12'h001;
         PCOP_HOLD: pc_next = pc_reg;
         PCOP_JUMP: pc_next = jump_target;
         PCOP_REL: pc_next = rel_sum;
         PCOP_RETURN: pc_next = ret_go ? sif.top : pc_reg + 12'h001;
         default: pc_next = pc_reg;
      endcase
   end

   // vector fetch: low then high byte, core stalled meanwhile
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_VEC_LO;
         vec_addr_reg <= VEC_RESET;
         vec_lo_reg <= REG_RESET;
         pc_reg <= VEC_RESET;
      end else if (ce) begin
         case (state_reg)
            ST_RUN: begin
               if (nmi_take) begin
                  vec_addr_reg <= VEC_NMI;
                  state_reg <= ST_VEC_LO;
               end else if (irq_take) begin
                  vec_addr_reg <= VEC_IRQ_LO + {9'h000, irq_vec_sel, 1'b0};
                  state_reg <= ST_VEC_LO;
               end else if (fetch) begin
                  pc_reg <= pc_next;
               end
            end
            ST_VEC_LO: begin
               vec_lo_reg <= rom_rdata;
               state_reg <= ST_VEC_HI;
            end
            ST_VEC_HI: begin
               pc_reg <= {rom_rdata[3:0], vec_lo_reg};
               state_reg <= ST_RUN;
            end
            default: state_reg <= ST_RUN;
         endcase
      end
   end

   assign busy = (state_reg != ST_RUN);
   always_comb begin
      case (state_reg)
         ST_VEC_LO: rom_addr = {prog_bank, vec_addr_reg};
         ST_VEC_HI: rom_addr = {prog_bank, vec_addr_reg + 12'h001};
         default: rom_addr = {prog_bank, pc_reg};
      endcase
   end
   assign window_rom_addr = {window_sel, data_addr[5:0]};
   assign program_counter = pc_reg;

   // =========================================
   // stack hookup
   assign sif.push = (state_reg == ST_RUN) && (taking_int || (fetch && is_call));
   assign sif.pop = (state_reg == ST_RUN) && !taking_int && fetch && (pc_op == PCOP_RETURN);
   // interrupts save the interrupted pc; calls save the return pc
   assign sif.push_data = taking_int ? pc_reg : pc_reg + 12'h001;

   mcseq_stack #(.DEPTH(STACK_DEPTH)) u_stack (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .sif(sif.stack)
   );

   // =========================================
   // context tracking
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctx_reg <= CTX_NMI;
         prev_ctx_reg <= CTX_NORMAL;
      end else if (ce && state_reg == ST_RUN) begin
         if (nmi_take) begin
            prev_ctx_reg <= ctx_reg;
            ctx_reg <= CTX_NMI;
         end else if (irq_take) begin
            prev_ctx_reg <= ctx_reg;
            ctx_reg <= CTX_IRQ;
         end else if (fetch && is_return_from_interrupt && pc_op == PCOP_RETURN) begin
            // one level of history: nmi over irq returns to irq, then normal
            ctx_reg <= prev_ctx_reg;
            prev_ctx_reg <= CTX_NORMAL;
         end
      end
   end
   assign active_ctx = ctx_reg;

   mcseq_flags u_flags (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .ctx(ctx_reg),
      .carry_we(carry_we),
      .carry_in(carry_in),
      .zero_we(zero_we),
      .result(alu_result),
      .carry(carry),
      .zero(zero)
   );

   // =========================================
   // data-space core registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ptr_one_reg <= REG_RESET;
         ptr_two_reg <= REG_RESET;
         short_one_reg <= REG_RESET;
         short_two_reg <= REG_RESET;
      end else if (ce && data_we) begin
         case (data_addr)
            ADDR_PTR_ONE: ptr_one_reg <= data_wdata;
            ADDR_PTR_TWO: ptr_two_reg <= data_wdata;
            ADDR_SHORT_ONE: short_one_reg <= data_wdata;
            ADDR_SHORT_TWO: short_two_reg <= data_wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      core_hit = 1'b1;
      case (data_addr)
         ADDR_PTR_ONE: core_rdata = ptr_one_reg;
         ADDR_PTR_TWO: core_rdata = ptr_two_reg;
         ADDR_SHORT_ONE: core_rdata = short_one_reg;
         ADDR_SHORT_TWO: core_rdata = short_two_reg;
         default: begin
            core_rdata = 8'h00;
            core_hit = 1'b0;
         end
      endcase
   end
   assign pointer_one = ptr_one_reg;
   assign pointer_two = ptr_two_reg;

   // =========================================
   // checks
   sequence s_vec_fetch;
      state_reg == ST_VEC_LO ##1 state_reg == ST_VEC_HI;
   endsequence
   property p_vec_two;
      @(posedge mclk) disable iff (!nrst)
         (ce && state_reg == ST_RUN && taking_int) |=> (ce [*2] and s_vec_fetch) ##1 !busy;
   endproperty
   a_vec_two: assert property (p_vec_two) else $error("vector fetch not two bytes");
   property p_inc;
      @(posedge mclk) disable iff (!nrst)
         (ce && !busy && !taking_int && fetch && pc_op == PCOP_NEXT) |=> pc_reg == $past(pc_reg) + 12'h001;
   endproperty
   a_inc: assert property (p_inc) else $error("pc did not advance");
   property p_jump;
      @(posedge mclk) disable iff (!nrst)
         (ce && !busy && !taking_int && fetch && pc_op == PCOP_JUMP) |=> pc_reg == $past(jump_target);
   endproperty
   a_jump: assert property (p_jump) else $error("jump target not loaded");
   property p_nmi_ctx;
      @(posedge mclk) disable iff (!nrst)
         (ce && !busy && nmi_take) |=> active_ctx == CTX_NMI;
   endproperty
   a_nmi_ctx: assert property (p_nmi_ctx) else $error("nmi context not entered");
   property p_ptr_wr;
      @(posedge mclk) disable iff (!nrst)
         (ce && data_we && data_addr == ADDR_PTR_ONE) |=> pointer_one == $past(data_wdata);
   endproperty
   a_ptr_wr: assert property (p_ptr_wr) else $error("pointer write lost");
   property p_short_wr;
      @(posedge mclk) disable iff (!nrst)
         (ce && data_we && data_addr == ADDR_SHORT_TWO)
         |=> short_two_reg == $past(data_wdata);
   endproperty
   a_short_wr: assert property (p_short_wr) else $error("short register write lost");
   property p_rel;
      @(posedge mclk) disable iff (!nrst)
         (ce && !busy && !taking_int && fetch && pc_op == PCOP_REL)
         |=> pc_reg == $past(pc_reg) + {{4{$past(rel_offset[7])}}, $past(rel_offset)};
   endproperty
   a_rel: assert property (p_rel) else $error("relative branch wrong");
   property p_ret_empty;
      @(posedge mclk) disable iff (!nrst)
         (ce && !busy && !taking_int && fetch && pc_op == PCOP_RETURN && sif.empty)
         |=> pc_reg == $past(pc_reg) + 12'h001;
   endproperty
   a_ret_empty: assert property (p_ret_empty) else $error("empty return changed flow");
   property p_return_from_interrupt_ctx;
      @(posedge mclk) disable iff (!nrst)
         (ce && !busy && !taking_int && fetch && is_return_from_interrupt && pc_op == PCOP_RETURN)
         |=> ctx_reg == $past(prev_ctx_reg);
   endproperty
   a_return_from_interrupt_ctx: assert property (p_return_from_interrupt_ctx) else $error("context not restored");
   // a frozen cycle must leave counter, context and fetch state alone
   property p_ce_hold;
      @(posedge mclk) disable iff (!nrst)
         !ce |=> pc_reg == $past(pc_reg) && ctx_reg == $past(ctx_reg)
            && state_reg == $past(state_reg);
   endproperty
   a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");
   property p_win;
      @(posedge mclk) window_rom_addr[5:0] == data_addr[5:0];
   endproperty
   a_win: assert property (p_win) else $error("window address wrong");
endmodule // mcu_core_sequencer
`default_nettype wire

// *** sim/mcseq_rom_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// program rom seen by the sequencer
module mcseq_rom_model
   import mcseq_pkg::*;
#(
   parameter int AW = 13
) (
   input wire logic [AW-1:0] addr,
   output logic [7:0] rdata
);
   // high vector bytes carry junk above bit 3, so a full-byte load shows up
   always_comb begin
      if (addr[11:0] == 12'hffe) begin
         rdata = 8'h5b;
      end else if (addr[11:0] == 12'hfff) begin
         rdata = 8'ha2;
      end else if (addr[11:0] == 12'hffc) begin
         rdata = 8'ha5;
      end else if (addr[11:0] == 12'hffd) begin
         rdata = 8'h93;
      end else if (addr[11:3] == 9'h1fe) begin
         rdata = addr[0] ? 8'hc4 : {2'b00, addr[2:1], 4'h6};
      end else begin
         rdata = addr[7:0] ^ 8'h3c;
      end
   end
endmodule // mcseq_rom_model
`default_nettype wire

// *** sim/mcu_core_sequencer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module mcu_core_sequencer_tb
   import mcseq_pkg::*;
;
   typedef struct {string name; logic [12:0] exp;} mcseq_note_s;
   logic mclk, nrst, ce, fetch, is_call, irq_take, nmi_take, is_return_from_interrupt;
   logic carry_we, carry_in, zero_we, data_we, busy, carry, zero, core_hit;
   logic [2:0] pc_op, data_region;
   logic [11:0] jump_target, program_counter, pc_m;
   logic [7:0] rel_offset, alu_result, data_addr, data_wdata, rom_rdata, core_rdata;
   logic [7:0] pointer_one, pointer_two;
   logic [1:0] irq_vec_sel, active_ctx, prog_region, ctx_m, prev_m;
   logic [0:0] prog_bank;
   logic [6:0] window_sel;
   logic [12:0] rom_addr, window_rom_addr;
   logic cf [3];
   logic zf [3];
   logic [7:0] regs_m [4];
   logic [11:0] stk [$];
   mcseq_note_s notes [$];
   int mismatches, total_checks;
   event check_now;

   mcu_core_sequencer #(.BANK_W(1)) u_mcu_core_sequencer (.mclk(mclk), .nrst(nrst), .ce(ce),
      .fetch(fetch), .pc_op(pc_op), .is_call(is_call), .jump_target(jump_target),
      .rel_offset(rel_offset), .irq_take(irq_take), .nmi_take(nmi_take),
      .irq_vec_sel(irq_vec_sel), .is_return_from_interrupt(is_return_from_interrupt), .prog_bank(prog_bank),
      .window_sel(window_sel), .carry_we(carry_we), .carry_in(carry_in), .zero_we(zero_we),
      .alu_result(alu_result), .data_addr(data_addr), .data_we(data_we),
      .data_wdata(data_wdata), .rom_rdata(rom_rdata), .program_counter(program_counter),
      .rom_addr(rom_addr), .window_rom_addr(window_rom_addr), .busy(busy),
      .active_ctx(active_ctx), .carry(carry), .zero(zero), .core_rdata(core_rdata),
      .core_hit(core_hit), .data_region(data_region), .prog_region(prog_region),
      .pointer_one(pointer_one), .pointer_two(pointer_two));
   mcseq_rom_model #(.AW(13)) u_mcseq_rom_model (.addr(rom_addr), .rdata(rom_rdata));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ==========================================
   // checking side
   initial begin : monitor
      mcseq_note_s n;
      logic [12:0] seen;
      forever begin
         @(check_now);
         while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.name)
               "pc": seen = {1'b0, program_counter};
               "ctx": seen = {11'h000, active_ctx};
               "busy": seen = {12'h000, busy};
               "rom": seen = rom_addr;
               "carry": seen = {12'h000, carry};
               "zero": seen = {12'h000, zero};
               "rdata": seen = {5'h00, core_rdata};
               "hit": seen = {12'h000, core_hit};
               "dreg": seen = {10'h000, data_region};
               "preg": seen = {11'h000, prog_region};
               "win": seen = window_rom_addr;
               "ptr1": seen = {5'h00, pointer_one};
               default: seen = {5'h00, pointer_two};
            endcase
            total_checks++;
            if (seen !== n.exp) begin
               mismatches++;
               $display("[ERR] %s exp %h seen %h", n.name, n.exp, seen);
            end
         end
      end
   end

   task automatic note(input string nm, input logic [12:0] v);
      notes.push_back('{nm, v});
   endtask
   // checks fire 2 ns after the call; one made straight after another chk lands on the rising edge
   task automatic chk();
      #2;
      ->check_now;
      #1;
   endtask
   task automatic push_m(input logic [11:0] v);
      stk.push_front(v);
      if (stk.size() > STACK_DEPTH) begin
         void'(stk.pop_back());
      end
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 10 && busy !== 1'b0; i++) begin
         @(negedge mclk);
      end
      note("busy", 13'h0000);
   endtask
   task automatic flags_now();
      note("carry", {12'h000, cf[ctx_m]});
      note("zero", {12'h000, zf[ctx_m]});
      chk();
   endtask

   // ==========================================
   // drivers
   task automatic step(input logic [2:0] op, input logic call, input logic return_from_interrupt,
                       input logic [11:0] tgt, input logic [7:0] off);
      @(negedge mclk);
      fetch = 1'b1;
      pc_op = op;
      is_call = call;
      is_return_from_interrupt = return_from_interrupt;
      jump_target = tgt;
      rel_offset = off;
      case (op)
         PCOP_NEXT: pc_m = pc_m + 12'h001;
         PCOP_JUMP: begin
            if (call) begin
               push_m(pc_m + 12'h001);
            end
            pc_m = tgt;
         end
         PCOP_REL: pc_m = pc_m + {{4{off[7]}}, off};
         PCOP_RETURN: begin
            pc_m = (stk.size() > 0) ? stk.pop_front() : pc_m + 12'h001;
            if (return_from_interrupt) begin
               ctx_m = prev_m;
               prev_m = CTX_NORMAL;
            end
         end
         default: pc_m = pc_m;
      endcase
      @(negedge mclk);
      fetch = 1'b0;
      is_call = 1'b0;
      is_return_from_interrupt = 1'b0;
      note("pc", {1'b0, pc_m});
      note("ctx", {11'h000, ctx_m});
      chk();
   endtask

   task automatic take_int(input logic nmi, input logic [1:0] sel);
      logic [11:0] vec;
      @(negedge mclk);
      irq_take = ~nmi;
      nmi_take = nmi;
      irq_vec_sel = sel;
      vec = nmi ? VEC_NMI : VEC_IRQ_LO + {9'h000, sel, 1'b0};
      push_m(pc_m);
      prev_m = ctx_m;
      ctx_m = nmi ? CTX_NMI : CTX_IRQ;
      pc_m = nmi ? 12'h3a5 : 12'h406 + {6'h00, sel, 4'h0};
      @(negedge mclk);
      irq_take = 1'b0;
      nmi_take = 1'b0;
      note("busy", 13'h0001);
      note("ctx", {11'h000, ctx_m});
      note("rom", {1'b0, vec});
      chk();
      @(negedge mclk);
      note("rom", {1'b0, vec + 12'h001});
      chk();
      wait_idle();
      note("pc", {1'b0, pc_m});
      chk();
   endtask

   task automatic flag_wr(input logic c, input logic [7:0] r);
      @(negedge mclk);
      carry_we = 1'b1;
      carry_in = c;
      zero_we = 1'b1;
      alu_result = r;
      cf[ctx_m] = c;
      zf[ctx_m] = (r == 8'h00);
      @(negedge mclk);
      carry_we = 1'b0;
      zero_we = 1'b0;
      flags_now();
   endtask

   task automatic dprobe(input logic [7:0] a, input logic [2:0] reg_exp);
      @(negedge mclk);
      data_addr = a;
      window_sel = 7'($urandom);
      note("dreg", {10'h000, reg_exp});
      note("win", {window_sel, a[5:0]});
      note("hit", {12'h000, a[7:2] == 6'h20});
      if (a[7:2] == 6'h20) begin
         note("rdata", {5'h00, regs_m[a[1:0]]});
      end
      chk();
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #40000;
      mismatches++;
      tally_and_finish();
   end

   // ==========================================
   // main sequence
   initial begin
      {nrst, fetch, is_call, irq_take, nmi_take, is_return_from_interrupt, carry_we, carry_in} = 8'h00;
      {zero_we, data_we, pc_op, irq_vec_sel, prog_bank, window_sel} = 15'h0000;
      {jump_target, rel_offset, alu_result, data_addr, data_wdata} = 44'h0;
      ce = 1'b1;
      ctx_m = CTX_NMI;
      prev_m = CTX_NORMAL;
      cf = '{1'b0, 1'b0, 1'b0};
      zf = '{1'b0, 1'b0, 1'b0};
      void'($urandom(81059));
      repeat (4) @(negedge mclk);
      note("pc", {1'b0, VEC_RESET});
      note("ctx", 13'h0002);
      chk();
      nrst = 1'b1;
      wait_idle();
      pc_m = 12'h25b;
      note("pc", 13'h025b);
      chk();
      flag_wr(1'b1, 8'h00);
      step(PCOP_RETURN, 1'b0, 1'b1, 12'h000, 8'h00);
      flags_now();
      for (int i = 0; i < 4; i++) begin
         flag_wr(1'($urandom), (i == 0) ? 8'h00 : 8'($urandom));
      end
      step(PCOP_NEXT, 1'b0, 1'b0, 12'h000, 8'h00);
      step(PCOP_HOLD, 1'b0, 1'b0, 12'h000, 8'h00);
      step(PCOP_JUMP, 1'b0, 1'b0, 12'($urandom), 8'h00);
      step(PCOP_REL, 1'b0, 1'b0, 12'h000, 8'hf0);
      step(PCOP_REL, 1'b0, 1'b0, 12'h000, 8'h7f);
      for (int i = 0; i < 7; i++) begin
         step(PCOP_JUMP, 1'b1, 1'b0, 12'($urandom), 8'h00);
      end
      for (int i = 0; i < 7; i++) begin
         step(PCOP_RETURN, 1'b0, 1'b0, 12'h000, 8'h00);
      end
      for (int s = 0; s < 4; s++) begin
         take_int(1'b0, 2'(s));
         flags_now();
         flag_wr(1'($urandom), 8'($urandom));
         take_int(1'b1, 2'b00);
         flags_now();
         step(PCOP_RETURN, 1'b0, 1'b1, 12'h000, 8'h00);
         flags_now();
         step(PCOP_RETURN, 1'b0, 1'b1, 12'h000, 8'h00);
         flags_now();
      end
      // clock enable low must freeze the counter
      @(negedge mclk);
      ce = 1'b0;
      fetch = 1'b1;
      @(negedge mclk);
      fetch = 1'b0;
      ce = 1'b1;
      note("pc", {1'b0, pc_m});
      chk();
      for (int i = 0; i < 4; i++) begin
         @(negedge mclk);
         data_addr = 8'h80 + 8'(i);
         data_wdata = 8'($urandom);
         data_we = 1'b1;
         regs_m[i] = data_wdata;
         @(negedge mclk);
         data_we = 1'b0;
      end
      note("ptr1", {5'h00, regs_m[0]});
      note("ptr2", {5'h00, regs_m[1]});
      chk();
      dprobe(8'h00, DSP_BANK);
      dprobe(8'h3f, DSP_BANK);
      dprobe(8'h40, DSP_WINDOW);
      dprobe(8'h7f, DSP_WINDOW);
      for (int i = 0; i < 4; i++) begin
         dprobe(8'h80 + 8'(i), DSP_CORE_REG);
      end
      dprobe(8'h84, DSP_RAM);
      dprobe(8'hbf, DSP_RAM);
      dprobe(8'hc0, DSP_OTHER);
      for (int i = 0; i < 8; i++) begin
         logic [11:0] t;
         logic [1:0] r;
         t = (i == 0) ? 12'h07f : (i == 1) ? 12'h080 : (i == 2) ? 12'hf9f :
             (i == 3) ? 12'hfa0 : (i == 4) ? 12'hff0 : (i == 5) ? 12'hff8 :
             (i == 6) ? 12'hffc : 12'hfff;
         r = (i == 0) ? PSP_RESERVED : (i < 3) ? PSP_USER :
             (i == 3 || i == 5) ? PSP_OTHER : PSP_VECTOR;
         step(PCOP_JUMP, 1'b0, 1'b0, t, 8'h00);
         @(negedge mclk);
         prog_bank = 1'($urandom);
         note("preg", {11'h000, r});
         note("rom", {prog_bank, t});
         chk();
      end
      tally_and_finish();
   end
endmodule // mcu_core_sequencer_tb
`default_nettype wire
